// ---- hdl/sarseq_pkg.sv ----
// Purpose: Constants for the converter sequencer.
// Assumes: Classic Wishbone slave, 32-bit data, word-aligned registers.
// Notes: Offsets are byte addresses.
package sarseq_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] OFF_SELECT = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_RES_LO = 8'h08;
    localparam logic [7:0] OFF_RES_HI = 8'h0C;
    localparam logic [7:0] OFF_SLEEP = 8'h10;
    // ==========================================
    // Control field positions
    localparam int CTRL_EN = 7;
    localparam int CTRL_START = 6;
    localparam int CTRL_FREE = 5;
    localparam int CTRL_DONE = 4;
    localparam int CTRL_IE = 3;
    localparam int CTRL_DIV_LSB = 0;
    localparam int SLEEP_IDLE = 0;
    localparam int SLEEP_VECTOR = 1;
    // ==========================================
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    // ==========================================
    // Timing in converter clock cycles; sample-hold points in half converter clock cycles
    localparam int CYC_NORMAL = 13;
    localparam int CYC_EXTENDED = 25;
    localparam int HALF_SH_NORMAL = 3;
    localparam int HALF_SH_EXTENDED = 27;
    typedef enum logic [1:0] {SARSEQ_IDLE, SARSEQ_WAIT, SARSEQ_CONV} sarseq_state_t;
endpackage

// ---- hdl/sar_adc_sequencer.sv ----
// Purpose: Control sequencer of a 10-bit successive-approximation converter.
// Assumes: Analog core answers with coreResult valid at completion.
// Notes: Converter clock is a clk-rate enable pair from the prescaler.
`timescale 1ns/10ps
// How it works
// [RL1] Result is 10 bits; zero is ground, all ones reference less one step.
// [RL2] Three-bit channel code picks one of eight inputs, 000 to 111.
// [RL3] Free-running bit chooses single starts or continuous conversions.
// [RL4] Channel choice reaches the core only while the converter is enabled.
// [RL5] Start bit set by writing one, reads high until the conversion finishes.
// [RL6] A channel written mid-conversion applies only after completion.
// [RL7] Reading low byte locks result registers until high byte read.
// [RL8] Done flag still sets when a locked result is discarded.
// [RL9] Software reads low byte before high byte.
// [RL10] Prescaler runs while enabled, held reset while disabled.
// [RL11] Conversion begins on next rising converter clock edge after start.
// [RL12] Normal conversion lasts 13 converter clocks.
// [RL13] First conversion after enabling is extended to 25 clocks.
// [RL14] Sample-hold at 1.5 clocks normal, 13.5 clocks extended.
// [RL15] Completion writes result, sets flag, clears start in single mode.
// [RL16] Free-running restarts at once with the start bit left high.
// [RL17] Idle sleep with enabled, idle, single mode, irq enabled starts conversion.
// [RL18] Completion in sleep raises the interrupt request.
// [RL19] Software keeps converter clock 50 to 200 kHz for full resolution.
// [RL20] Upper five select bits read as zero.
// [RL21] Divider codes 000,001 give 2, doubling up to 128 at 111.
// [RL22] Clearing enable aborts any conversion.
// [RL23] Start stays high through extended plus real conversion; writing zero ignored.
// [RL24] Done flag clears on vector taken or on writing one.
module sar_adc_sequencer (
    input wire logic clk,
    input wire logic srst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic cpuHalted,
    input wire logic [9:0] coreResult,
    output logic [2:0] channelCode,
    output logic sampleHold,
    output logic coreActive,
    output logic convIrq
);
    // ==========================================
    // Registers
    logic [2:0] selectReg_q;
    logic enable_q, start_q, free_q, done_q, irqEn_q, idleSleep_q;
    logic [2:0] divSel_q;
    logic [6:0] presc_q;
    logic adcTick;
    logic [9:0] result_q;
    logic lock_q, firstConv_q, extended_q, ack_q;
    logic [5:0] halfCnt_q;
    logic [4:0] cycCnt_q;
    sarseq_pkg::sarseq_state_t state_q;
    logic wrStb, rdStb, complete, wrCtrl, vectorTaken;
    logic [7:0] addr;

    // Divide ratio as the prescaler terminal count
    function automatic logic [6:0] div_last(input logic [2:0] code);
        logic [7:0] ratio;
        ratio = (code == 3'h0) ? 8'h02 : 8'h01 << code;
        return 7'(ratio - 8'h01); // [RL21]
    endfunction

    assign addr = wb_adr_i[7:0];
    assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    assign rdStb = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
    assign wrCtrl = wrStb && addr == sarseq_pkg::OFF_CTRL;
    assign vectorTaken = wrStb && addr == sarseq_pkg::OFF_SLEEP
        && wb_dat_i[sarseq_pkg::SLEEP_VECTOR];
    assign wb_ack_o = ack_q;
    assign wb_err_o = 1'b0;

    // ==========================================
    // Bus answer: one wait state, unmapped reads return zero
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rdStb) begin
            if (addr == sarseq_pkg::OFF_SELECT) begin
                wb_dat_o <= {29'h0, selectReg_q}; // [RL20]
            end else if (addr == sarseq_pkg::OFF_CTRL) begin
                wb_dat_o <= {24'h0, enable_q, start_q, free_q, done_q, irqEn_q, divSel_q};
            end else if (addr == sarseq_pkg::OFF_RES_LO) begin
                wb_dat_o <= {24'h0, result_q[7:0]};
            end else if (addr == sarseq_pkg::OFF_RES_HI) begin
                wb_dat_o <= {30'h0, result_q[9:8]};
            end else if (addr == sarseq_pkg::OFF_SLEEP) begin
                wb_dat_o <= {31'h0, idleSleep_q};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // Software-owned control fields
    always_ff @(posedge clk) begin
        if (srst) begin
            selectReg_q <= sarseq_pkg::SELECT_RESET;
            {enable_q, free_q, irqEn_q} <= 3'h0;
            divSel_q <= sarseq_pkg::CTRL_RESET[2:0];
            idleSleep_q <= 1'b0;
        end else begin
            if (wrStb && addr == sarseq_pkg::OFF_SELECT) begin
                selectReg_q <= wb_dat_i[2:0]; // [RL2]
            end
            if (wrCtrl) begin
                enable_q <= wb_dat_i[sarseq_pkg::CTRL_EN];
                free_q <= wb_dat_i[sarseq_pkg::CTRL_FREE]; // [RL3]
                irqEn_q <= wb_dat_i[sarseq_pkg::CTRL_IE];
                divSel_q <= wb_dat_i[sarseq_pkg::CTRL_DIV_LSB +: 3];
            end
            if (wrStb && addr == sarseq_pkg::OFF_SLEEP) begin
                idleSleep_q <= wb_dat_i[sarseq_pkg::SLEEP_IDLE];
            end else if (convIrq) begin
                idleSleep_q <= 1'b0; // Wake on completion interrupt [RL18]
            end
        end
    end

    // ==========================================
    // Prescaler: tick marks each rising converter clock edge
    always_ff @(posedge clk) begin
        if (srst || !enable_q) begin
            presc_q <= 7'h00; // [RL10]
        end else if (presc_q >= div_last(divSel_q)) begin
            presc_q <= 7'h00;
        end else begin
            presc_q <= presc_q + 7'h01;
        end
    end
    assign adcTick = enable_q && presc_q == div_last(divSel_q);

    // Half-cycle mark so sample-hold lands mid converter period
    logic halfTick;
    logic [6:0] divLast;
    assign divLast = div_last(divSel_q);
    assign halfTick = enable_q && presc_q == {1'b0, divLast[6:1]};

    // ==========================================
    // Conversion sequencer
    assign complete = state_q == sarseq_pkg::SARSEQ_CONV && adcTick
        && cycCnt_q == 5'(extended_q ? sarseq_pkg::CYC_EXTENDED - 1
        : sarseq_pkg::CYC_NORMAL - 1); // [RL12] [RL13]

    always_ff @(posedge clk) begin
        if (srst || !enable_q) begin
            state_q <= sarseq_pkg::SARSEQ_IDLE; // [RL22]
            start_q <= 1'b0;
            cycCnt_q <= 5'h00;
            halfCnt_q <= 6'h00;
            extended_q <= 1'b0;
            firstConv_q <= 1'b1; // [RL13]
            // Start written together with enable must not be lost
            if (!srst && wrCtrl && wb_dat_i[sarseq_pkg::CTRL_EN]
                && wb_dat_i[sarseq_pkg::CTRL_START]) begin
                start_q <= 1'b1; // [RL5] [RL13]
                state_q <= sarseq_pkg::SARSEQ_WAIT;
            end
        end else begin
            case (state_q)
                sarseq_pkg::SARSEQ_IDLE: begin
                    if ((wrCtrl && wb_dat_i[sarseq_pkg::CTRL_START]) // [RL5] [RL23]
                        || (idleSleep_q && cpuHalted && !free_q && irqEn_q)) begin // [RL17]
                        start_q <= 1'b1;
                        state_q <= sarseq_pkg::SARSEQ_WAIT;
                    end
                end
                sarseq_pkg::SARSEQ_WAIT: begin
                    if (adcTick) begin
                        state_q <= sarseq_pkg::SARSEQ_CONV; // [RL11]
                        extended_q <= firstConv_q;
                        firstConv_q <= 1'b0;
                        cycCnt_q <= 5'h00;
                        halfCnt_q <= 6'h00;
                    end
                end
                sarseq_pkg::SARSEQ_CONV: begin
                    if (adcTick || halfTick) begin
                        halfCnt_q <= halfCnt_q + 6'h01;
                    end
                    if (complete) begin
                        cycCnt_q <= 5'h00;
                        halfCnt_q <= 6'h00;
                        extended_q <= 1'b0;
                        if (!free_q) begin
                            start_q <= 1'b0; // [RL15]
                            state_q <= sarseq_pkg::SARSEQ_IDLE;
                        end // Else next conversion begins at once [RL16]
                    end else if (adcTick) begin
                        cycCnt_q <= cycCnt_q + 5'h01;
                    end
                end
                default: state_q <= sarseq_pkg::SARSEQ_IDLE;
            endcase
        end
    end

    // Sample-hold pulse at the documented half-cycle count
    assign sampleHold = state_q == sarseq_pkg::SARSEQ_CONV && (adcTick || halfTick)
        && halfCnt_q == 6'(extended_q ? sarseq_pkg::HALF_SH_EXTENDED - 1
        : sarseq_pkg::HALF_SH_NORMAL - 1); // [RL14]
    assign coreActive = state_q == sarseq_pkg::SARSEQ_CONV;

    // ==========================================
    // Channel latch: only while enabled and between conversions
    always_ff @(posedge clk) begin
        if (srst) begin
            channelCode <= sarseq_pkg::SELECT_RESET;
        end else if (enable_q && (state_q != sarseq_pkg::SARSEQ_CONV || complete)) begin
            channelCode <= selectReg_q; // [RL4] [RL6]
        end
    end

    // ==========================================
    // Result lock and data registers
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_q <= 1'b0;
            result_q <= 10'h000;
        end else begin
            if (complete && !lock_q) begin
                result_q <= coreResult; // [RL1] [RL7]
            end
            if (rdStb && addr == sarseq_pkg::OFF_RES_HI) begin
                lock_q <= 1'b0; // [RL9]
            end else if (rdStb && addr == sarseq_pkg::OFF_RES_LO) begin
                lock_q <= 1'b1; // [RL7]
            end
        end
    end

    // Done flag: set beats clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else if (complete) begin
            done_q <= 1'b1; // [RL8] [RL15]
        end else if ((wrCtrl && wb_dat_i[sarseq_pkg::CTRL_DONE]) || vectorTaken) begin
            done_q <= 1'b0; // [RL24]
        end
    end
    assign convIrq = done_q && irqEn_q; // [RL18]

    // ==========================================
    // Checks
    a_done_after_complete: assert property (@(posedge clk) disable iff (srst)
        complete |=> done_q) else $error("done flag not set"); // [RL8]
    a_single_clears_start: assert property (@(posedge clk) disable iff (srst)
        complete && !free_q |=> !start_q) else $error("start not cleared"); // [RL15]
    a_free_keeps_start: assert property (@(posedge clk) disable iff (srst)
        complete && free_q && enable_q |=> start_q) else $error("start dropped"); // [RL16]
    a_locked_result_held: assert property (@(posedge clk) disable iff (srst)
        complete && lock_q |=> $stable(result_q)) else $error("locked result moved"); // [RL7]
    a_disable_aborts: assert property (@(posedge clk) disable iff (srst)
        !enable_q && !wrCtrl |=> !coreActive && !start_q) else $error("not aborted"); // [RL22]
    a_presc_held: assert property (@(posedge clk) disable iff (srst)
        !enable_q |=> presc_q == 7'h00) else $error("prescaler ran"); // [RL10]
    a_channel_frozen: assert property (@(posedge clk) disable iff (srst)
        coreActive && $past(coreActive) && !$past(complete) |-> $stable(channelCode))
        else $error("channel moved mid conversion"); // [RL6]
    a_start_during_conv: assert property (@(posedge clk) disable iff (srst)
        coreActive |-> start_q) else $error("start low while converting"); // [RL5]
endmodule

// ---- testbench/sarseq_core_model.sv ----
// Purpose: Behavioural analog core facing the converter sequencer.
// Assumes: The result is taken while coreActive is high or one cycle later.
// Notes: Outside a conversion the result lines toggle, so stale data never matches.
`timescale 1ns/10ps
module sarseq_core_model (
    input wire logic clk,
    input wire logic coreActive,
    input wire logic [2:0] channelCode,
    input wire logic [6:0] level,
    output logic [9:0] coreResult
);
    logic active_q;
    logic [9:0] junk_q;
    // ======
    // Released lines show the inverse of their last value every cycle
    always_ff @(posedge clk) begin
        active_q <= coreActive;
        junk_q <= ~coreResult;
    end
    // Code carries the selected input in its top bits
    assign coreResult = (coreActive || active_q) ? {channelCode, level} : junk_q;
endmodule

// ---- testbench/sar_adc_sequencer_bench.sv ----
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Ack comes one cycle after a request is taken.
// Notes: All prescaler codes are short at 40 MHz, so no count is scaled.
`timescale 1ns/10ps
module sar_adc_sequencer_bench;
    localparam logic [7:0] A_CTL = sarseq_pkg::OFF_CTRL;
    localparam logic [7:0] A_LO = sarseq_pkg::OFF_RES_LO;
    localparam logic [7:0] A_HI = sarseq_pkg::OFF_RES_HI;
    localparam logic [31:0] EN = 32'h80;
    localparam logic [31:0] GO = 32'h40;
    localparam logic [31:0] DONE = 32'h10;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cpuHalted = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, lfsr = 32'h0000FF4A;
    logic [3:0] sel = 4'h0;
    logic ack, err, sh, act, irq;
    logic [2:0] chan, oldCh;
    logic [9:0] core, expRes;
    logic [6:0] level = 7'h00;
    int nErrors = 0, nCompared = 0, n, sa, f;
    // ======
    // Clock, design and far side
    always #12.5 clk = ~clk;
    sar_adc_sequencer dut (.clk(clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .wb_err_o(err), .cpuHalted(cpuHalted), .coreResult(core),
        .channelCode(chan), .sampleHold(sh), .coreActive(act), .convIrq(irq));
    sarseq_core_model core0 (.clk(clk), .coreActive(act), .channelCode(chan),
        .level(level), .coreResult(core));
    // ======
    // Shared tasks
    task automatic printVerdict();
        $display("Compared %0d, errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Request held until ack is seen or 20 cycles pass, then released
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        {cyc, stb, we, sel} <= {2'h3, w, 4'hF};
        adr <= {24'h0, a};
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        {cyc, stb} <= 2'h0;
        if (k >= 20)
            chk(32'h0, 32'h1, "no ack");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp, what);
    endtask
    // Counts active cycles and notes where sample-hold fell
    task automatic span();
        n = 0;
        sa = -1;
        repeat (300) if (act !== 1'b1) @(posedge clk);
        while (act === 1'b1 && n < 4000) begin
            if (sh === 1'b1)
                sa = n;
            @(posedge clk);
            n++;
        end
    endtask
    // Level stays put during a conversion; the model reads it then
    task automatic newLevel();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        level <= lfsr[6:0];
    endtask
    // ======
    // Watchdog sized well above the roughly 4000 cycles of the run
    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        printVerdict();
    end
    // ======
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(A_CTL, 32'h0, "ctrl reset");
        rd(8'h00, 32'h0, "select reset");
        rd(8'h14, 32'h0, "unmapped");
        bus(1'b1, 8'h00, 32'hFD);
        rd(8'h00, 32'h5, "select reserved");
        chk(chan, 3'h0, "chan while off");
        $display("Test registers done");
        newLevel();
        bus(1'b1, A_CTL, EN | GO);
        fork
            span();
            bus(1'b1, A_CTL, EN);
        join
        chk(n, 50, "extended length");
        chk(sa, sarseq_pkg::HALF_SH_EXTENDED - 1, "extended hold");
        rd(A_CTL, EN | DONE, "ctrl after first");
        chk(chan, 3'h5, "chan on enable");
        expRes = {3'h5, level};
        rd(A_LO, expRes[7:0], "first low");
        rd(A_HI, expRes[9:8], "first high");
        $display("Test extended done");
        for (int c = 1; c < 8; c++) begin
            f = (c < 2) ? 2 : (1 << c);
            oldCh = (c == 1) ? 3'h5 : 3'(c - 1);
            newLevel();
            bus(1'b1, A_CTL, EN | GO | DONE | c);
            fork
                span();
                begin
                    wait (act === 1'b1);
                    bus(1'b1, 8'h00, c);
                    chk(chan, oldCh, "chan mid run");
                end
            join
            chk(n, 13 * f, "normal length");
            chk(sa, sarseq_pkg::HALF_SH_NORMAL * f / 2 - 1, "normal hold");
            chk(chan, c, "chan after done");
            rd(A_CTL, EN | DONE | c, "ctrl after done");
            expRes = {oldCh, level};
            rd(A_LO, expRes[7:0], "low byte");
            rd(A_HI, expRes[9:8], "high byte");
        end
        $display("Test prescaler and channel done");
        rd(A_LO, expRes[7:0], "lock low");
        newLevel();
        bus(1'b1, A_CTL, EN | GO | DONE | 32'h1);
        span();
        rd(A_CTL, EN | DONE | 32'h1, "flag when lost");
        rd(A_HI, expRes[9:8], "locked high");
        rd(A_LO, expRes[7:0], "lost low");
        rd(A_HI, expRes[9:8], "lost high");
        $display("Test lock done");
        bus(1'b1, A_CTL, EN | GO | 32'h20 | DONE | 32'h1);
        // Core stays active in free run, so time one sample-hold to the next
        repeat (200) if (sh !== 1'b1) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sh !== 1'b1 && n < 4000);
        chk(n, 26, "free run length");
        rd(A_CTL, EN | GO | 32'h20 | DONE | 32'h1, "free start high");
        bus(1'b1, A_CTL, 32'h0);
        @(posedge clk);
        chk(act, 1'b0, "abort");
        $display("Test free run and abort done");
        bus(1'b1, A_CTL, EN | 32'h08 | DONE | 32'h1);
        cpuHalted <= 1'b1;
        bus(1'b1, sarseq_pkg::OFF_SLEEP, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk(irq, 1'b1, "sleep irq");
        cpuHalted <= 1'b0;
        bus(1'b1, sarseq_pkg::OFF_SLEEP, 32'h2);
        chk(irq, 1'b0, "vector clears");
        $display("Test sleep done");
        printVerdict();
    end
endmodule
